/* lpmc_pkg.sv */
// lpmc_pkg: constants and carrier types for the low-power mode and port control block
// assumes a 250 MHz core clock; register port is a plain strobe bus
package lpmc_pkg;
    // register addresses
    localparam logic [7:0] LPMC_ADDR_PWR = 8'h87;
    localparam logic [7:0] LPMC_ADDR_P1 = 8'h90;
    localparam logic [7:0] LPMC_ADDR_P2 = 8'hA0;
    localparam logic [7:0] LPMC_ADDR_P3 = 8'hB0;
    localparam logic [7:0] LPMC_ADDR_ID0 = 8'hF8;
    // power_control_reg field positions
    localparam int LPMC_IDLE_BIT = 0;
    localparam int LPMC_PD_BIT = 1;
    localparam int LPMC_GF0_BIT = 2;
    localparam int LPMC_GF1_BIT = 3;
    localparam int LPMC_SMOD_BIT = 7;
    localparam logic [7:0] LPMC_PWR_WMASK = 8'h8F;
    localparam logic [7:0] LPMC_PWR_RST = 8'h00;
    localparam logic [7:0] LPMC_PORT_RST = 8'hFF;
    // timing, counted in osc periods (one osc period = one core clock here)
    localparam int LPMC_OSC_PER_MC = 12;
    localparam int LPMC_RST_MC = 2;
    localparam int LPMC_RST_CYC = LPMC_OSC_PER_MC * LPMC_RST_MC;
    localparam int LPMC_KICK_CYC = 2;
    localparam logic [63:0] LPMC_ID_DEFAULT = 64'h0123_4567_89AB_CDEF; // arbitrary value

    typedef enum logic [2:0] {
        LPMC_RUN = 3'b001,
        LPMC_IDLE = 3'b010,
        LPMC_PDOWN = 3'b100
    } lpmc_mode_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } lpmc_req_t;

    typedef struct packed {
        logic ext_active;
        logic ext_code;
        logic [7:0] addr_hi;
        logic table_read;
        logic table_from_ext;
        logic table_int_target;
        logic verify;
        logic [7:0] verify_byte;
    } lpmc_core_t;

    typedef struct packed {
        logic [7:0] pd_en;
        logic [7:0] strong_en;
        logic [7:0] keep_en;
    } lpmc_drv_t;
endpackage

/* lpmc_port_drv.sv */
// lpmc_port_drv: output driver control for one 8-bit quasi-bidirectional port
// assumes latch data comes from logic on the same clock
module lpmc_port_drv (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic [7:0] i_latch,
    input wire logic [7:0] i_force_strong,
    output lpmc_pkg::lpmc_drv_t o_drv
);
    typedef struct packed {
        logic [7:0] prev;
        logic [7:0][1:0] kick;
        lpmc_pkg::lpmc_drv_t drv;
    } lpmc_pd_state_t;
    lpmc_pd_state_t st_q, st_d;

    always_comb begin
        st_d = st_q;
        st_d.prev = i_latch;
        for (int b = 0; b < 8; b++) begin
            if (!i_latch[b]) begin
                st_d.kick[b] = 2'b00;
            end else if (!st_q.prev[b]) begin
                st_d.kick[b] = 2'(lpmc_pkg::LPMC_KICK_CYC - 1);
            end else if (st_q.kick[b] != 2'b00) begin
                st_d.kick[b] = st_q.kick[b] - 2'b01;
            end
            st_d.drv.pd_en[b] = !i_latch[b];
            st_d.drv.strong_en[b] = i_latch[b] && (i_force_strong[b] || (!st_q.prev[b])
                || (st_q.kick[b] != 2'b00));
            st_d.drv.keep_en[b] = i_latch[b];
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            st_q <= '{prev: 8'hFF, kick: '0, drv: '{pd_en: 8'h00, strong_en: 8'h00, keep_en: 8'hFF}};
        end else begin
            st_q <= st_d;
        end
    end

    assign o_drv = st_q.drv;
endmodule // lpmc_port_drv

/* lpmc_top.sv */
// lpmc_top: idle / power-down control, pin states, port drivers, secure and id options
// assumes the core and timers sit outside; clock is the 250 MHz core clock
//
// The register offsets and the plain strobed port are this design's own decisions.
module lpmc_top #(
    parameter logic [63:0] ID_VALUE = lpmc_pkg::LPMC_ID_DEFAULT, // arbitrary value
    parameter logic [63:0] KEY_ARRAY = 64'h5A3C_96E1_0F7B_D248 // arbitrary key
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_rst_pin,
    input wire logic i_ext_access_sel,
    input wire logic i_secure_en,
    input wire logic i_irq_pending,
    input wire lpmc_pkg::lpmc_req_t i_req,
    input wire lpmc_pkg::lpmc_core_t i_core,
    output logic [7:0] o_rdata,
    output logic o_osc_enable,
    output logic o_cpu_clk_en,
    output logic o_periph_clk_en,
    output logic o_clk_half,
    output logic o_int_rst,
    output logic o_ext_exec,
    output logic o_table_block,
    output logic [7:0] o_verify_data,
    output logic o_addr_latch_strobe,
    output logic o_program_fetch_strobe,
    output logic [7:0] o_port0_out,
    output logic [7:0] o_port0_oe,
    output logic [7:0] o_port2_out,
    output lpmc_pkg::lpmc_drv_t o_port1_drv,
    output lpmc_pkg::lpmc_drv_t o_port2_drv,
    output lpmc_pkg::lpmc_drv_t o_port3_drv,
    output lpmc_pkg::lpmc_mode_t o_mode
);
    ////////////////////////////////////////////////////////////////////////////
    // state
    typedef struct packed {
        logic rs1;
        logic rs2;
        logic [4:0] rcnt;
        logic irst;
        logic ea_lat;
        logic half;
        lpmc_pkg::lpmc_mode_t mode;
        logic pd_ext;
        logic [7:0] pwr;
        logic [7:0] p1;
        logic [7:0] p2;
        logic [7:0] p3;
        logic [7:0] rdata;
        logic [7:0] vdata;
        logic ale;
        logic program_fetch_strobe;
    } lpmc_state_t;
    lpmc_state_t st_q, st_d;

    logic [7:0] rd_mux;
    logic [7:0] p2_strong;
    logic [2:0] id_idx;
    assign id_idx = i_req.addr[2:0];

    ////////////////////////////////////////////////////////////////////////////
    // read mux
    always_comb begin
        rd_mux = 8'h00;
        if (i_req.addr == lpmc_pkg::LPMC_ADDR_PWR) begin
            rd_mux = st_q.pwr & lpmc_pkg::LPMC_PWR_WMASK;
        end else if (i_req.addr == lpmc_pkg::LPMC_ADDR_P1) begin
            rd_mux = st_q.p1;
        end else if (i_req.addr == lpmc_pkg::LPMC_ADDR_P2) begin
            rd_mux = st_q.p2;
        end else if (i_req.addr == lpmc_pkg::LPMC_ADDR_P3) begin
            rd_mux = st_q.p3;
        end else if (i_req.addr[7:3] == lpmc_pkg::LPMC_ADDR_ID0[7:3]) begin
            rd_mux = ID_VALUE[id_idx*8 +: 8];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        st_d = st_q;
        // the first synchroniser stage feeds only the second
        st_d.rs1 = i_rst_pin;
        st_d.rs2 = st_q.rs1;
        if (!st_q.rs2) begin
            st_d.rcnt = 5'd0;
        end else if (st_q.rcnt != 5'(lpmc_pkg::LPMC_RST_CYC)) begin
            st_d.rcnt = st_q.rcnt + 5'd1;
        end
        // short glitches on the pin do not reset; 24 osc periods are needed
        st_d.irst = st_q.rs2 && (st_q.rcnt == 5'(lpmc_pkg::LPMC_RST_CYC - 1) || st_q.irst);
        st_d.half = !st_q.half;
        st_d.rdata = i_req.rd ? rd_mux : 8'h00;
        if (st_q.irst) begin
            st_d.mode = lpmc_pkg::LPMC_RUN;
            st_d.pwr = lpmc_pkg::LPMC_PWR_RST;
            st_d.p1 = lpmc_pkg::LPMC_PORT_RST;
            st_d.p2 = lpmc_pkg::LPMC_PORT_RST;
            st_d.p3 = lpmc_pkg::LPMC_PORT_RST;
            st_d.pd_ext = 1'b0;
            st_d.ea_lat = i_ext_access_sel;
        end else begin
            if (!i_secure_en) begin
                st_d.ea_lat = i_ext_access_sel;
            end
            case (st_q.mode)
                lpmc_pkg::LPMC_RUN: begin
                    if (i_req.wr) begin
                        case (i_req.addr)
                            lpmc_pkg::LPMC_ADDR_PWR: begin
                                st_d.pwr = i_req.wdata & lpmc_pkg::LPMC_PWR_WMASK;
                                if (i_req.wdata[lpmc_pkg::LPMC_PD_BIT]) begin
                                    st_d.mode = lpmc_pkg::LPMC_PDOWN;
                                    st_d.pd_ext = i_core.ext_code;
                                end else if (i_req.wdata[lpmc_pkg::LPMC_IDLE_BIT]) begin
                                    st_d.mode = lpmc_pkg::LPMC_IDLE;
                                end
                            end
                            lpmc_pkg::LPMC_ADDR_P1: st_d.p1 = i_req.wdata;
                            lpmc_pkg::LPMC_ADDR_P2: st_d.p2 = i_req.wdata;
                            lpmc_pkg::LPMC_ADDR_P3: st_d.p3 = i_req.wdata;
                            default: st_d.p1 = st_q.p1;
                        endcase
                    end
                end
                lpmc_pkg::LPMC_IDLE: begin
                    if (i_irq_pending) begin
                        st_d.pwr[lpmc_pkg::LPMC_IDLE_BIT] = 1'b0;
                        st_d.mode = lpmc_pkg::LPMC_RUN;
                    end
                end
                // power-down holds mode and registers frozen: no write, no interrupt exit
                lpmc_pkg::LPMC_PDOWN: st_d.mode = lpmc_pkg::LPMC_PDOWN;
                default: st_d.mode = lpmc_pkg::LPMC_RUN;
            endcase
        end
        // verify output is never clear code when secured
        st_d.vdata = i_secure_en ? (i_core.verify_byte ^ KEY_ARRAY[i_core.addr_hi[2:0]*8 +: 8])
            : i_core.verify_byte;
        case (st_d.mode)
            lpmc_pkg::LPMC_IDLE: begin
                st_d.ale = 1'b1;
                st_d.program_fetch_strobe = 1'b1;
            end
            lpmc_pkg::LPMC_PDOWN: begin
                st_d.ale = 1'b0;
                st_d.program_fetch_strobe = 1'b0;
            end
            default: begin
                st_d.ale = i_core.ext_active;
                st_d.program_fetch_strobe = !(i_core.ext_active && i_core.ext_code);
            end
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            st_q <= '{rs1: 1'b0, rs2: 1'b0, rcnt: 5'd0, irst: 1'b0, ea_lat: 1'b0, half: 1'b0,
                mode: lpmc_pkg::LPMC_RUN, pd_ext: 1'b0, pwr: lpmc_pkg::LPMC_PWR_RST,
                p1: lpmc_pkg::LPMC_PORT_RST, p2: lpmc_pkg::LPMC_PORT_RST, p3: lpmc_pkg::LPMC_PORT_RST,
                rdata: 8'h00, vdata: 8'h00, ale: 1'b1, program_fetch_strobe: 1'b1};
        end else begin
            st_q <= st_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // pins and drivers
    logic ext_bus;
    assign ext_bus = !st_q.ea_lat;
    assign o_ext_exec = ext_bus;
    assign o_mode = st_q.mode;
    assign o_rdata = st_q.rdata;
    assign o_osc_enable = (st_q.mode != lpmc_pkg::LPMC_PDOWN);
    assign o_cpu_clk_en = (st_q.mode == lpmc_pkg::LPMC_RUN);
    assign o_periph_clk_en = o_osc_enable;
    assign o_clk_half = st_q.half;
    assign o_int_rst = st_q.irst;
    assign o_table_block = i_secure_en && i_core.table_read && i_core.table_from_ext
        && i_core.table_int_target;
    assign o_verify_data = st_q.vdata;
    assign o_addr_latch_strobe = st_q.ale;
    assign o_program_fetch_strobe = st_q.program_fetch_strobe;
    // port0 always floats: o_port0_oe is 8'h00 whether or not the external bus owns it or power-down was entered from external code
    assign o_port0_out = 8'h00;
    assign o_port0_oe = (ext_bus || (st_q.mode == lpmc_pkg::LPMC_PDOWN && st_q.pd_ext)) ? 8'h00
        : ~st_q.p1 & 8'h00;
    logic p2_addr;
    assign p2_addr = i_core.ext_active && (st_q.mode != lpmc_pkg::LPMC_PDOWN)
        && (st_q.mode == lpmc_pkg::LPMC_RUN || ext_bus);
    assign o_port2_out = p2_addr ? i_core.addr_hi : st_q.p2;
    assign p2_strong = p2_addr ? i_core.addr_hi
        : ((st_q.mode == lpmc_pkg::LPMC_PDOWN) ? st_q.p2 : 8'h00);

    lpmc_port_drv u_p1 (.i_clk(i_clk), .i_rst(i_rst), .i_latch(st_q.p1), .i_force_strong(8'h00),
        .o_drv(o_port1_drv));
    lpmc_port_drv u_p2 (.i_clk(i_clk), .i_rst(i_rst), .i_latch(o_port2_out), .i_force_strong(p2_strong),
        .o_drv(o_port2_drv));
    lpmc_port_drv u_p3 (.i_clk(i_clk), .i_rst(i_rst), .i_latch(st_q.p3), .i_force_strong(8'h00),
        .o_drv(o_port3_drv));
endmodule // lpmc_top

/* lpmc_top_asserts.sv */
// lpmc_top_asserts: port-level checks for lpmc_top
// assumes it is bound into lpmc_top and sees only that module's ports
module lpmc_top_asserts (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_rst_pin,
    input wire logic i_secure_en,
    input wire logic i_irq_pending,
    input wire lpmc_pkg::lpmc_core_t i_core,
    input wire logic o_osc_enable,
    input wire logic o_cpu_clk_en,
    input wire logic o_periph_clk_en,
    input wire logic o_int_rst,
    input wire logic o_table_block,
    input wire logic o_addr_latch_strobe,
    input wire logic o_program_fetch_strobe,
    input wire logic [7:0] o_port2_out,
    input wire lpmc_pkg::lpmc_drv_t o_port1_drv,
    input wire lpmc_pkg::lpmc_drv_t o_port2_drv,
    input wire lpmc_pkg::lpmc_mode_t o_mode
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    // run length of the raw reset pin, saturating so long holds never wrap
    logic [7:0] pin_cnt_q;
    always_ff @(posedge i_clk) begin
        if (!i_rst_pin) pin_cnt_q <= 8'h00;
        else if (pin_cnt_q != 8'hFF) pin_cnt_q <= pin_cnt_q + 8'h01;
    end
    ////////////////////////////////////////////////////////////
    AST_PD_PINS: assert property (o_mode == lpmc_pkg::LPMC_PDOWN |->
        !o_osc_enable && !o_addr_latch_strobe && !o_program_fetch_strobe) else $error("power-down pin state wrong");
    AST_IDLE_PINS: assert property (o_mode == lpmc_pkg::LPMC_IDLE |->
        o_addr_latch_strobe && o_program_fetch_strobe && !o_cpu_clk_en && o_periph_clk_en)
        else $error("idle pins wrong");
    AST_PD_HOLD: assert property (o_mode == lpmc_pkg::LPMC_PDOWN && !o_int_rst |=>
        o_mode == lpmc_pkg::LPMC_PDOWN || o_int_rst) else $error("power-down left without reset");
    AST_IRQ_WAKE: assert property (o_mode == lpmc_pkg::LPMC_IDLE && i_irq_pending |=>
        o_mode == lpmc_pkg::LPMC_RUN) else $error("interrupt did not end idle");
    AST_RST_LATE: assert property (pin_cnt_q == 8'd40 |-> o_int_rst) else $error("long reset pin ignored");
    AST_PULL: assert property ((o_port1_drv.pd_en & (o_port1_drv.strong_en | o_port1_drv.keep_en)) == 8'h00)
        else $error("pull-down and pull-up both on");
    AST_KICK: assert property ($rose(o_port1_drv.strong_en[0]) |->
        o_port1_drv.strong_en[0] ##1 o_port1_drv.strong_en[0] ##1 !o_port1_drv.strong_en[0]) else $error("kick length");
    AST_ADDR_STRONG: assert property (
        (o_mode == lpmc_pkg::LPMC_RUN && i_core.ext_active && $stable(i_core.addr_hi))[*3]
        |-> (o_port2_out & ~o_port2_drv.strong_en) == 8'h00) else $error("address one without strong pull-up");
    AST_TBL: assert property (i_secure_en && i_core.table_read && i_core.table_from_ext && i_core.table_int_target
        |-> o_table_block) else $error("table read not blocked");
    COV_IDLE_WAKE: cover property (o_mode == lpmc_pkg::LPMC_IDLE ##1 o_mode == lpmc_pkg::LPMC_RUN);
    COV_PD: cover property (o_mode == lpmc_pkg::LPMC_PDOWN ##1 o_int_rst);
    COV_KICK: cover property ($rose(o_port1_drv.strong_en[0]));
endmodule // lpmc_top_asserts
bind lpmc_top lpmc_top_asserts lpmc_top_asserts_inst (.i_clk, .i_rst, .i_rst_pin, .i_secure_en, .i_irq_pending,
    .i_core, .o_osc_enable, .o_cpu_clk_en, .o_periph_clk_en, .o_int_rst, .o_table_block, .o_addr_latch_strobe,
    .o_program_fetch_strobe, .o_port2_out, .o_port1_drv, .o_port2_drv, .o_mode);

/* lpmc_ext_mem.sv */
// lpmc_ext_mem: external memory side of the multiplexed bus
// assumes the bench opens and closes each access just after a clock edge
module lpmc_ext_mem (
    input wire logic i_clk,
    input wire logic i_go,
    input wire logic [7:0] i_addr,
    input wire logic i_tbl,
    input wire logic i_vfy,
    output lpmc_pkg::lpmc_core_t o_core
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] last_q = 8'h5A;
    // released bus shows a pattern that alternates each cycle between the inverse of the last address and the last address
    always @(posedge i_clk) last_q <= i_go ? i_addr : ~last_q;
    always_comb begin
        o_core = '0;
        o_core.ext_active = i_go;
        o_core.ext_code = i_go;
        o_core.addr_hi = i_go ? i_addr : ~last_q;
        o_core.table_read = i_tbl;
        o_core.table_from_ext = i_tbl;
        o_core.table_int_target = i_tbl;
        o_core.verify = i_vfy;
        o_core.verify_byte = 8'h3C;
    end
endmodule // lpmc_ext_mem

/* tb_lpmc_top.sv */
// tb_lpmc_top: directed bench for the low-power and port control block
// assumes lpmc_ext_mem drives the core bus side and the checker is bound
module tb_lpmc_top;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [63:0] ID = 64'h1122_3344_5566_7788; // arbitrary value
    logic i_clk = 0, i_rst = 1, i_rst_pin = 0, i_ext_access_sel = 1, i_secure_en = 0, i_irq_pending = 0;
    logic go = 0, tbl = 0, vfy = 0;
    logic [7:0] addr = 8'hA5;
    lpmc_pkg::lpmc_req_t i_req = '0;
    lpmc_pkg::lpmc_core_t i_core;
    logic [7:0] o_rdata, o_verify_data, o_port0_out, o_port0_oe, o_port2_out;
    logic o_osc_enable, o_cpu_clk_en, o_periph_clk_en, o_clk_half, o_int_rst, o_ext_exec, o_table_block;
    logic o_addr_latch_strobe, o_program_fetch_strobe;
    lpmc_pkg::lpmc_drv_t o_port1_drv, o_port2_drv, o_port3_drv;
    lpmc_pkg::lpmc_mode_t o_mode;
    int num_errors = 0, compares = 0, cycles = 0;
    lpmc_top #(.ID_VALUE(ID)) lpmc_top_inst (.i_clk, .i_rst, .i_rst_pin, .i_ext_access_sel, .i_secure_en,
        .i_irq_pending, .i_req, .i_core, .o_rdata, .o_osc_enable, .o_cpu_clk_en, .o_periph_clk_en, .o_clk_half,
        .o_int_rst, .o_ext_exec, .o_table_block, .o_verify_data, .o_addr_latch_strobe, .o_program_fetch_strobe,
        .o_port0_out, .o_port0_oe, .o_port2_out, .o_port1_drv, .o_port2_drv, .o_port3_drv, .o_mode);
    lpmc_ext_mem lpmc_ext_mem_inst (.i_clk, .i_go(go), .i_addr(addr), .i_tbl(tbl), .i_vfy(vfy), .o_core(i_core));
    always #2 i_clk = ~i_clk;
    ////////////////////////////////////////////////////////////
    task automatic give_verdict;
        if (num_errors == 0 && compares > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 3000) begin
            num_errors++;
            give_verdict();
        end
    end
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk) i_req <= '{a, d, 1'b1, 1'b0};
        @(posedge i_clk) i_req <= '0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge i_clk) i_req <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge i_clk) i_req <= '0;
        #1 chk(o_rdata, e);
    endtask
    task automatic pin_pulse(input int len);
        @(posedge i_clk) i_rst_pin <= 1'b1;
        repeat (len) @(posedge i_clk);
        i_rst_pin <= 1'b0;
        cyc(6);
    endtask
    ////////////////////////////////////////////////////////////
    task automatic test_regs;
        logic h;
        h = o_clk_half;
        cyc(1);
        chk(o_clk_half ^ h, 1'b1);
        rd(lpmc_pkg::LPMC_ADDR_PWR, lpmc_pkg::LPMC_PWR_RST);
        for (int k = 0; k < 8; k++) rd(lpmc_pkg::LPMC_ADDR_ID0 + 8'(k), ID[8*k +: 8]);
        rd(8'h91, 8'h00);
    endtask
    task automatic test_idle;
        wr(lpmc_pkg::LPMC_ADDR_PWR, 8'h0D);
        chk({o_mode, o_addr_latch_strobe, o_program_fetch_strobe, o_cpu_clk_en}, {lpmc_pkg::LPMC_IDLE, 3'b110});
        @(posedge i_clk) go <= 1'b1;
        cyc(2);
        chk({o_port2_out, o_port0_oe, o_port0_out}, 24'hFF_0000);
        @(posedge i_clk) i_ext_access_sel <= 1'b0;
        cyc(2);
        chk({o_port2_out, o_port0_oe}, 16'hA500);
        @(posedge i_clk) go <= 1'b0;
        i_ext_access_sel <= 1'b1;
        wr(lpmc_pkg::LPMC_ADDR_PWR, 8'h00);
        chk(o_mode, lpmc_pkg::LPMC_IDLE);
        @(posedge i_clk) i_irq_pending <= 1'b1;
        @(posedge i_clk) i_irq_pending <= 1'b0;
        #1 chk(o_mode, lpmc_pkg::LPMC_RUN);
        rd(lpmc_pkg::LPMC_ADDR_PWR, 8'h0C);
        wr(lpmc_pkg::LPMC_ADDR_PWR, 8'h01);
        pin_pulse(30);
        chk(o_mode, lpmc_pkg::LPMC_RUN);
        rd(lpmc_pkg::LPMC_ADDR_PWR, 8'h00);
    endtask
    task automatic test_ports;
        logic [3:0] n;
        n = 4'h0;
        wr(lpmc_pkg::LPMC_ADDR_P1, 8'h00);
        cyc(3);
        chk({o_port1_drv.pd_en, o_port1_drv.strong_en, o_port1_drv.keep_en}, 24'hFF_0000);
        wr(lpmc_pkg::LPMC_ADDR_P3, 8'h0F);
        cyc(3);
        chk(o_port3_drv, 24'hF0_000F);
        wr(lpmc_pkg::LPMC_ADDR_P1, 8'h01);
        repeat (6) begin
            n = n + 4'(o_port1_drv.strong_en[0]);
            cyc(1);
        end
        chk(n, 4'h2);
        @(posedge i_clk) go <= 1'b1;
        cyc(3);
        chk(o_port2_out & o_port2_drv.strong_en, 8'hA5);
        @(posedge i_clk) go <= 1'b0;
    endtask
    task automatic test_powerdown;
        wr(lpmc_pkg::LPMC_ADDR_P1, 8'h55);
        wr(lpmc_pkg::LPMC_ADDR_P2, 8'h3C);
        @(posedge i_clk) go <= 1'b1;
        wr(lpmc_pkg::LPMC_ADDR_PWR, 8'h03);
        chk({o_mode, o_osc_enable, o_addr_latch_strobe, o_program_fetch_strobe}, {lpmc_pkg::LPMC_PDOWN, 3'b000});
        cyc(3);
        chk({o_port2_out, o_port2_out & o_port2_drv.strong_en, o_port1_drv.pd_en}, 24'h3C_3CAA);
        @(posedge i_clk) go <= 1'b0;
        wr(lpmc_pkg::LPMC_ADDR_P1, 8'h00);
        pin_pulse(10);
        chk({o_mode, o_port1_drv.pd_en}, {lpmc_pkg::LPMC_PDOWN, 8'hAA});
        @(posedge i_clk) i_secure_en <= 1'b1;
        i_ext_access_sel <= 1'b0;
        pin_pulse(48);
        chk({o_mode, o_port1_drv.pd_en, o_ext_exec}, {lpmc_pkg::LPMC_RUN, 8'h00, 1'b1});
        @(posedge i_clk) i_ext_access_sel <= 1'b1;
        cyc(3);
        chk(o_ext_exec, 1'b1);
        rd(lpmc_pkg::LPMC_ADDR_PWR, 8'h00);
    endtask
    task automatic test_secure;
        @(posedge i_clk) tbl <= 1'b1;
        cyc(1);
        chk(o_table_block, 1'b1);
        @(posedge i_clk) tbl <= 1'b0;
        vfy <= 1'b1;
        cyc(2);
        chk(o_verify_data == 8'h3C, 1'b0);
        @(posedge i_clk) i_secure_en <= 1'b0;
        cyc(2);
        chk(o_verify_data, 8'h3C);
        @(posedge i_clk) vfy <= 1'b0;
    endtask
    initial begin
        repeat (20) @(posedge i_clk);
        i_rst <= 1'b0;
        cyc(2);
        test_regs();
        test_idle();
        test_ports();
        test_powerdown();
        test_secure();
        give_verdict();
    end
endmodule // tb_lpmc_top
